// *** src/conv_cfg_pkg.sv ***
package conv_cfg_pkg;

  // register byte offsets
  localparam logic [14:0] ADDR_SYNC_LOW_COUNT_LIMIT = 15'h0210;
  localparam logic [14:0] ADDR_OVERRANGE_LEVEL      = 15'h0211;
  localparam logic [14:0] ADDR_OVERRANGE_CONFIG     = 15'h0213;
  localparam logic [14:0] ADDR_INIT_STATUS          = 15'h0270;
  localparam logic [14:0] ADDR_POWER_PROFILE_2      = 15'h029a;
  localparam logic [14:0] ADDR_POWER_PROFILE_3      = 15'h029b;
  localparam logic [14:0] ADDR_POWER_PROFILE_4      = 15'h029c;

  // reset values
  localparam logic [4:0] RST_SYNC_LOW_COUNT_LIMIT = 5'h03;
  localparam logic [7:0] RST_OVERRANGE_LEVEL      = 8'hf2;
  localparam logic       RST_OVERRANGE_ENABLE     = 1'h0;
  localparam logic [2:0] RST_OVERRANGE_HOLD_EXP   = 3'h7;
  localparam logic [7:0] RST_POWER_PROFILE_2      = 8'h0f;
  localparam logic [7:0] RST_POWER_PROFILE_3      = 8'h04;
  localparam logic [7:0] RST_POWER_PROFILE_4      = 8'h1b;

  // field positions
  localparam int SYNC_LIMIT_MSB  = 4;
  localparam int OVR_ENABLE_BIT  = 3;
  localparam int OVR_HOLD_MSB    = 2;
  localparam int INIT_DONE_BIT   = 0;

  // power profile codes
  localparam logic [7:0] PP2_LOW_POWER = 8'h06;
  localparam logic [7:0] PP3_LOW_POWER = 8'h00;
  localparam logic [7:0] PP4_LOW_POWER = 8'h14;

  // over-range stretch base: 4 * 2^n sampling cycles
  localparam logic [9:0] OVR_HOLD_BASE = 10'h004;

  // initialization time and derived count
  localparam int CLK_PERIOD_NS   = 20;
  localparam int INIT_TIME_NS    = 1000;
  localparam int INIT_CYCLES_INT = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INIT_CYCLES = INIT_CYCLES_INT[7:0];

  // serial frame layout
  localparam logic [4:0] SPI_HDR_BITS   = 5'h10;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

  localparam int NUM_CH = 4;

  typedef struct packed {
    logic                   valid;
    logic [NUM_CH-1:0][11:0] data;
  } sample_bus_type;

  typedef struct packed {
    logic pp2_low_power;
    logic pp3_low_power;
    logic pp4_low_power;
  } power_mode_type;

endpackage

// *** src/sync_filter_overrange_config.sv ***
`timescale 1ns/1ns
// Overview of operation
// - sample sync input every link clock cycle
// - request only after limit-plus-one low samples
// - shorter low runs are error reports, ignored
// - flag channel when sample magnitude reaches 8 times level
// - flags driven only while overrange enable set
// - stretch flag to 4 times 2^hold sampling cycles
// - init status bit reads 1 after init
// - profile 2: 0x06 low power, 0x0f high
// - profile 3: 0x00 low power, 0x04 high
module sync_filter_overrange_config
  import conv_cfg_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_resetn,
  input  wire logic           i_spi_sclk,
  input  wire logic           i_spi_csn,
  input  wire logic           i_spi_sdi,
  output logic                o_spi_sdo,
  output logic                o_spi_sdo_oe,
  input  wire logic           i_link_tick,
  input  wire logic           i_sync_n,
  output logic                o_sync_request,
  input  wire sample_bus_type i_samples,
  output logic                o_overrange_flag_a,
  output logic                o_overrange_flag_b,
  output logic                o_overrange_flag_c,
  output logic                o_overrange_flag_d,
  output power_mode_type      o_power_mode
);

  // pin synchronisers: three stages each
  logic [2:0] sclk_s_r;
  logic [2:0] csn_s_r;
  logic [2:0] sdi_s_r;
  logic [2:0] sync_s_r;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_s_r <= 3'h0;
      csn_s_r  <= 3'h7;
      sdi_s_r  <= 3'h0;
      sync_s_r <= 3'h7;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], i_spi_sclk};
      csn_s_r  <= {csn_s_r[1:0], i_spi_csn};
      sdi_s_r  <= {sdi_s_r[1:0], i_spi_sdi};
      sync_s_r <= {sync_s_r[1:0], i_sync_n};
    end
  end

  logic sclk_last_r, sclk_last_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic csn_hi;
  logic sync_lo;
  assign sclk_rise = sclk_s_r[1] & sclk_s_r[2] & ~sclk_last_r;
  assign sclk_fall = ~sclk_s_r[1] & ~sclk_s_r[2] & sclk_last_r;
  assign csn_hi    = csn_s_r[1] & csn_s_r[2];
  assign sync_lo   = ~sync_s_r[1] & ~sync_s_r[2];

  // register file and serial slave state
  logic [23:0] shift_r, shift_nxt;
  logic [4:0]  bit_cnt_r, bit_cnt_nxt;
  logic [7:0]  out_r, out_nxt;
  logic        is_read_r, is_read_nxt;
  logic        sdo_r, sdo_nxt;
  logic        sdo_oe_r, sdo_oe_nxt;
  logic [4:0]  sync_limit_r, sync_limit_nxt;
  logic [7:0]  ovr_level_r, ovr_level_nxt;
  logic        ovr_enable_r, ovr_enable_nxt;
  logic [2:0]  ovr_hold_r, ovr_hold_nxt;
  logic [7:0]  pp2_r, pp2_nxt;
  logic [7:0]  pp3_r, pp3_nxt;
  logic [7:0]  pp4_r, pp4_nxt;
  logic [7:0]  init_cnt_r, init_cnt_nxt;
  logic        init_done_r, init_done_nxt;
  logic [5:0]  low_cnt_r, low_cnt_nxt;
  logic        sync_req_r, sync_req_nxt;
  power_mode_type pmode_r, pmode_nxt;

  function automatic logic [7:0] read_mux(input logic [14:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_SYNC_LOW_COUNT_LIMIT: v[SYNC_LIMIT_MSB:0] = sync_limit_r;
      ADDR_OVERRANGE_LEVEL:      v = ovr_level_r;
      ADDR_OVERRANGE_CONFIG: begin
        v[OVR_ENABLE_BIT]   = ovr_enable_r;
        v[OVR_HOLD_MSB:0]   = ovr_hold_r;
      end
      ADDR_INIT_STATUS:          v[INIT_DONE_BIT] = init_done_r;
      ADDR_POWER_PROFILE_2:      v = pp2_r;
      ADDR_POWER_PROFILE_3:      v = pp3_r;
      ADDR_POWER_PROFILE_4:      v = pp4_r;
      default:                   v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    sclk_last_nxt  = sclk_s_r[2];
    shift_nxt      = shift_r;
    bit_cnt_nxt    = bit_cnt_r;
    out_nxt        = out_r;
    is_read_nxt    = is_read_r;
    sdo_nxt        = sdo_r;
    sdo_oe_nxt     = sdo_oe_r;
    sync_limit_nxt = sync_limit_r;
    ovr_level_nxt  = ovr_level_r;
    ovr_enable_nxt = ovr_enable_r;
    ovr_hold_nxt   = ovr_hold_r;
    pp2_nxt        = pp2_r;
    pp3_nxt        = pp3_r;
    pp4_nxt        = pp4_r;

    // serial slave: 1 rw bit, 15 address bits, 8 data bits
    if (csn_hi) begin
      bit_cnt_nxt = 5'h00;
      sdo_oe_nxt  = 1'b0;
      is_read_nxt = 1'b0;
    end else if (sclk_rise && bit_cnt_r != SPI_FRAME_BITS) begin
      shift_nxt   = {shift_r[22:0], sdi_s_r[2]};
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      if (bit_cnt_nxt == SPI_HDR_BITS && shift_nxt[15]) begin
        is_read_nxt = 1'b1;
        out_nxt     = read_mux(shift_nxt[14:0]);
      end
      if (bit_cnt_nxt == SPI_FRAME_BITS && !shift_nxt[23]) begin
        // reserved bits are not stored and read back zero
        case (shift_nxt[22:8])
          ADDR_SYNC_LOW_COUNT_LIMIT: sync_limit_nxt = shift_nxt[SYNC_LIMIT_MSB:0];
          ADDR_OVERRANGE_LEVEL:      ovr_level_nxt = shift_nxt[7:0];
          ADDR_OVERRANGE_CONFIG: begin
            ovr_enable_nxt = shift_nxt[OVR_ENABLE_BIT];
            ovr_hold_nxt   = shift_nxt[OVR_HOLD_MSB:0];
          end
          ADDR_POWER_PROFILE_2:      pp2_nxt = shift_nxt[7:0];
          ADDR_POWER_PROFILE_3:      pp3_nxt = shift_nxt[7:0];
          ADDR_POWER_PROFILE_4:      pp4_nxt = shift_nxt[7:0];
          default:                   pp2_nxt = pp2_r;
        endcase
      end
    end else if (sclk_fall && is_read_r) begin
      sdo_oe_nxt = 1'b1;
      sdo_nxt    = out_r[7];
      out_nxt    = {out_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_last_r  <= 1'b0;
      shift_r      <= 24'h000000;
      bit_cnt_r    <= 5'h00;
      out_r        <= 8'h00;
      is_read_r    <= 1'b0;
      sdo_r        <= 1'b0;
      sdo_oe_r     <= 1'b0;
      sync_limit_r <= RST_SYNC_LOW_COUNT_LIMIT;
      ovr_level_r  <= RST_OVERRANGE_LEVEL;
      ovr_enable_r <= RST_OVERRANGE_ENABLE;
      ovr_hold_r   <= RST_OVERRANGE_HOLD_EXP;
      pp2_r        <= RST_POWER_PROFILE_2;
      pp3_r        <= RST_POWER_PROFILE_3;
      pp4_r        <= RST_POWER_PROFILE_4;
    end else begin
      sclk_last_r  <= sclk_last_nxt;
      shift_r      <= shift_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      out_r        <= out_nxt;
      is_read_r    <= is_read_nxt;
      sdo_r        <= sdo_nxt;
      sdo_oe_r     <= sdo_oe_nxt;
      sync_limit_r <= sync_limit_nxt;
      ovr_level_r  <= ovr_level_nxt;
      ovr_enable_r <= ovr_enable_nxt;
      ovr_hold_r   <= ovr_hold_nxt;
      pp2_r        <= pp2_nxt;
      pp3_r        <= pp3_nxt;
      pp4_r        <= pp4_nxt;
    end
  end

  // initialization sequencer: status stays low until the counter runs out
  always_comb begin
    init_cnt_nxt  = init_cnt_r;
    init_done_nxt = init_done_r;
    if (init_cnt_r != INIT_CYCLES) begin
      init_cnt_nxt = init_cnt_r + 8'h01;
    end else begin
      init_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      init_cnt_r  <= 8'h00;
      init_done_r <= 1'b0;
    end else begin
      init_cnt_r  <= init_cnt_nxt;
      init_done_r <= init_done_nxt;
    end
  end

  // sync filter on link clock samples
  always_comb begin
    low_cnt_nxt  = low_cnt_r;
    sync_req_nxt = sync_req_r;
    if (i_link_tick) begin
      if (sync_lo) begin
        // count saturates so a long low run keeps the request up
        if (low_cnt_r != 6'h3f) begin
          low_cnt_nxt = low_cnt_r + 6'h01;
        end
        sync_req_nxt = (low_cnt_nxt > {1'b0, sync_limit_r});
      end else begin
        // a short run only clears the count; nothing is raised
        low_cnt_nxt  = 6'h00;
        sync_req_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt_r  <= 6'h00;
      sync_req_r <= 1'b0;
    end else begin
      low_cnt_r  <= low_cnt_nxt;
      sync_req_r <= sync_req_nxt;
    end
  end

  // power mode decode: reset codes select high performance
  always_comb begin
    pmode_nxt.pp2_low_power = (pp2_r == PP2_LOW_POWER);
    pmode_nxt.pp3_low_power = (pp3_r == PP3_LOW_POWER);
    pmode_nxt.pp4_low_power = (pp4_r == PP4_LOW_POWER);
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pmode_r <= '0;
    end else begin
      pmode_r <= pmode_nxt;
    end
  end

  // over-range detection per channel
  logic [NUM_CH-1:0] flag_r;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ovr
    logic [11:0] mag;
    logic        hit;
    logic [9:0]  hold_r, hold_nxt;
    logic        fl_nxt;

    always_comb begin
      mag      = i_samples.data[ch][11] ? 12'(-i_samples.data[ch]) : i_samples.data[ch];
      hit      = i_samples.valid && (mag >= {1'b0, ovr_level_r, 3'h0});
      hold_nxt = hold_r;
      if (hit) begin
        hold_nxt = 10'(OVR_HOLD_BASE << ovr_hold_r);
      end else if (i_samples.valid && hold_r != 10'h000) begin
        hold_nxt = hold_r - 10'h001;
      end
      fl_nxt = ovr_enable_r && (hold_nxt != 10'h000);
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        hold_r     <= 10'h000;
        flag_r[ch] <= 1'b0;
      end else begin
        hold_r     <= hold_nxt;
        flag_r[ch] <= fl_nxt;
      end
    end
  end

  assign o_overrange_flag_a = flag_r[0];
  assign o_overrange_flag_b = flag_r[1];
  assign o_overrange_flag_c = flag_r[2];
  assign o_overrange_flag_d = flag_r[3];
  assign o_sync_request     = sync_req_r;
  assign o_spi_sdo          = sdo_r;
  assign o_spi_sdo_oe       = sdo_oe_r;
  assign o_power_mode       = pmode_r;

endmodule

// *** verification/sync_rx_model.sv ***
`timescale 1ns/1ns
module sync_rx_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_link_tick,
  input  wire logic       i_start,
  input  wire logic [5:0] i_run,
  output logic            o_sync_n,
  output logic            o_busy
);
  // holds the line low for a commanded count of link cycles, else high
  initial begin
    o_sync_n = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk_sys iff i_start);
      o_busy <= #1 1'b1;
      @(posedge i_clk_sys iff i_link_tick);
      o_sync_n <= #1 1'b0;
      repeat (i_run) @(posedge i_clk_sys iff i_link_tick);
      o_sync_n <= #1 1'b1;
      repeat (3) @(posedge i_clk_sys iff i_link_tick);
      o_busy <= #1 1'b0;
    end
  end
endmodule

// *** verification/sync_filter_overrange_config_props.sv ***
`timescale 1ns/1ns
module sync_filter_overrange_config_props
  import conv_cfg_pkg::*;
(
  input wire logic           i_clk_sys,
  input wire logic           i_resetn,
  input wire logic           i_spi_sclk,
  input wire logic           i_spi_csn,
  input wire logic           i_spi_sdi,
  input wire logic           o_spi_sdo,
  input wire logic           o_spi_sdo_oe,
  input wire logic           i_link_tick,
  input wire logic           i_sync_n,
  input wire logic           o_sync_request,
  input wire sample_bus_type i_samples,
  input wire logic           o_overrange_flag_a,
  input wire logic           o_overrange_flag_b,
  input wire logic           o_overrange_flag_c,
  input wire logic           o_overrange_flag_d,
  input wire power_mode_type o_power_mode
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  req_on_tick_a: assert property ($rose(o_sync_request) |-> $past(i_link_tick))
    else $error("request rose off a tick");
  req_drop_tick_a: assert property ($fell(o_sync_request) |-> $past(i_link_tick))
    else $error("request fell off a tick");
  no_req_high_a: assert property (i_sync_n [*8] |=> !$rose(o_sync_request))
    else $error("request with line high");
  hold_a_a: assert property ($rose(o_overrange_flag_a) |=> o_overrange_flag_a [*3])
    else $error("flag a too short");
  hold_d_a: assert property ($rose(o_overrange_flag_d) |=> o_overrange_flag_d [*3])
    else $error("flag d too short");
  cause_a_a: assert property ($rose(o_overrange_flag_a) |-> $past(i_samples.valid))
    else $error("flag a without sample");
  cause_c_a: assert property ($rose(o_overrange_flag_c) |-> $past(i_samples.valid))
    else $error("flag c without sample");
  sdo_idle_a: assert property (i_spi_csn [*5] |-> !o_spi_sdo_oe)
    else $error("sdo driven while deselected");
  mode_frame_a: assert property ($changed(o_power_mode) |-> !$past(i_spi_csn))
    else $error("power mode moved outside a frame");
  cover property ($rose(o_sync_request));
  cover property ($rose(o_overrange_flag_a));
  cover property (o_power_mode == 3'h7);
endmodule
bind sync_filter_overrange_config sync_filter_overrange_config_props i_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_spi_sclk(i_spi_sclk), .i_spi_csn(i_spi_csn),
  .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe),
  .i_link_tick(i_link_tick), .i_sync_n(i_sync_n), .o_sync_request(o_sync_request),
  .i_samples(i_samples), .o_overrange_flag_a(o_overrange_flag_a),
  .o_overrange_flag_b(o_overrange_flag_b), .o_overrange_flag_c(o_overrange_flag_c),
  .o_overrange_flag_d(o_overrange_flag_d), .o_power_mode(o_power_mode));

// *** verification/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import conv_cfg_pkg::*;
  logic           clk = 1'b0, rstn = 1'b0, sclk = 1'b0, csn = 1'b1, sdi = 1'b0;
  logic           tick = 1'b0, start = 1'b0, clr = 1'b0;
  logic           sdo, oe, sync_n, req, fa, fb, fc, fd, busy;
  logic [5:0]     run = 6'h00;
  logic [7:0]     rd;
  sample_bus_type smp = '{valid: 1'b1, data: '0};
  power_mode_type pm;
  int             n_fail = 0, n_compared = 0, req_cyc = 0, ovr_cyc = 0, tcnt = 0;
  logic [14:0]    ra [7] = '{ADDR_SYNC_LOW_COUNT_LIMIT, ADDR_OVERRANGE_LEVEL,
    ADDR_OVERRANGE_CONFIG, ADDR_POWER_PROFILE_2, ADDR_POWER_PROFILE_3,
    ADDR_POWER_PROFILE_4, 15'h0212};
  logic [7:0]     rv [7] = '{8'h03, 8'hf2, 8'h07, 8'h0f, 8'h04, 8'h1b, 8'h00};
  logic [7:0]     lo [3] = '{8'h06, 8'h00, 8'h14};
  logic [5:0]     lim [5] = '{6'h03, 6'h03, 6'h00, 6'h1f, 6'h1f};
  logic [5:0]     rl [5] = '{6'h03, 6'h04, 6'h01, 6'h1f, 6'h20};
  logic [7:0]     ex [5] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    tcnt <= (tcnt + 1) % 4;
    tick <= #1 (tcnt == 3);
    req_cyc <= clr ? 0 : req_cyc + req;
    ovr_cyc <= clr ? 0 : ovr_cyc + fa;
  end
  sync_filter_overrange_config i_sync_filter_overrange_config (
    .i_clk_sys(clk), .i_resetn(rstn), .i_spi_sclk(sclk), .i_spi_csn(csn), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .i_link_tick(tick), .i_sync_n(sync_n),
    .o_sync_request(req), .i_samples(smp), .o_overrange_flag_a(fa), .o_overrange_flag_b(fb),
    .o_overrange_flag_c(fc), .o_overrange_flag_d(fd), .o_power_mode(pm));
  sync_rx_model i_sync_rx_model (.i_clk_sys(clk), .i_link_tick(tick), .i_start(start),
    .i_run(run), .o_sync_n(sync_n), .o_busy(busy));
  task automatic clk_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] f;
    f = {rw, a, wd};
    csn = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      clk_wait(5);
      if (i < 8) rd[i] = sdo;
      sclk = 1'b1;
      clk_wait(4);
      sclk = 1'b0;
    end
    chk("sdo enable", {7'h0, rw}, {7'h0, oe});
    clk_wait(4);
    csn = 1'b1;
    clk_wait(6);
    chk("sdo release", 8'h00, {7'h0, oe});
  endtask
  task automatic sync_run(input logic [5:0] n);
    clr = 1'b1;
    run = n;
    start = 1'b1;
    clk_wait(1);
    clr = 1'b0;
    start = 1'b0;
    clk_wait(2);
    for (int k = 0; k < 400 && busy !== 1'b0; k++) clk_wait(1);
    clk_wait(8);
    chk("model idle", 8'h00, {7'h0, busy});
  endtask
  task automatic hit();
    smp.data = {12'h800, 12'h870, 12'h78f, 12'h790};
    clr = 1'b1;
    clk_wait(1);
    smp.data = '0;
    clr = 1'b0;
    clk_wait(1);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
  initial begin
    clk_wait(12);
    rstn = 1'b1;
    clk_wait(60);
    spi(1'b1, ADDR_INIT_STATUS, 8'h00);
    chk("init_status", 8'h01, rd);
    for (int i = 0; i < 7; i++) begin
      spi(1'b1, ra[i], 8'h00);
      chk("reset value", rv[i], rd);
    end
    chk("power mode", 8'h00, {5'h0, pm});
    for (int i = 0; i < 3; i++) spi(1'b0, ra[i + 3], lo[i]);
    chk("power mode", 8'h07, {5'h0, pm});
    spi(1'b1, ADDR_POWER_PROFILE_2, 8'h00);
    chk("profile 2", 8'h06, rd);
    for (int i = 0; i < 3; i++) spi(1'b0, ra[i + 3], rv[i + 3]);
    chk("power mode", 8'h00, {5'h0, pm});
    for (int i = 0; i < 5; i++) begin
      spi(1'b0, ADDR_SYNC_LOW_COUNT_LIMIT, {2'h0, lim[i]});
      sync_run(rl[i]);
      chk("sync request", ex[i], {7'h0, req_cyc > 0});
    end
    spi(1'b0, ADDR_OVERRANGE_CONFIG, 8'h00);
    hit();
    chk("flags off", 8'h00, {4'h0, fd, fc, fb, fa});
    for (int h = 0; h < 3; h += 2) begin
      spi(1'b0, ADDR_OVERRANGE_CONFIG, {5'h1, h[2:0]});
      hit();
      chk("flags", 8'h0d, {4'h0, fd, fc, fb, fa});
      clk_wait(80);
      chk("stretch", 8'h01, {7'h0, ovr_cyc >= (4 << h) && ovr_cyc <= (4 << h) + 1});
    end
    finish_test();
  end
endmodule
